// ==== hdl/ecsr_pkg.sv ====
/*
 package for the ethernet control and status register group: offsets, field positions,
 reset values, codes and carrier structs. assumes an apb slave at 32-bit word offsets.
*/
package ecsr_pkg;
   localparam logic [11:0] ECSR_OFF_CONTROL = 12'h000;
   localparam logic [11:0] ECSR_OFF_TXSTAT = 12'h004;
   localparam logic [11:0] ECSR_OFF_STATUS = 12'h008;
   localparam logic [11:0] ECSR_OFF_SCRATCH = 12'h00c;
   localparam logic [15:0] ECSR_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] ECSR_SCRATCH_RESET = 16'h0000;
   localparam logic [15:0] ECSR_PAUSE_ZERO = 16'h0000;
   localparam int ECSR_BIT_EXP = 15;
   localparam int ECSR_BIT_DIG_EN = 14;
   localparam int ECSR_BIT_DIG_IV = 13;
   localparam int ECSR_BIT_DIG_LAST = 12;
   localparam int ECSR_BIT_CIPHER = 11;
   localparam int ECSR_CIPH_HI = 10;
   localparam int ECSR_CIPH_LO = 9;
   localparam int ECSR_BIT_PACKET_COUNT_DECREMENT = 8;
   localparam int ECSR_FLOW_HI = 7;
   localparam int ECSR_FLOW_LO = 6;
   localparam int ECSR_BIT_COPY = 5;
   localparam int ECSR_BIT_COPY_EN = 4;
   localparam int ECSR_BIT_SEED = 3;
   localparam int ECSR_BIT_NOCS = 2;
   localparam int ECSR_BIT_TXREQ = 1;
   localparam int ECSR_BIT_RECEIVE_ENABLE = 0;
   localparam logic [1:0] ECSR_FLOW_IDLE = 2'h0;
   localparam logic [1:0] ECSR_FLOW_SINGLE = 2'h1;
   localparam logic [1:0] ECSR_FLOW_PERIODIC = 2'h2;
   localparam logic [1:0] ECSR_FLOW_END = 2'h3;
   localparam logic [1:0] ECSR_CIPH_RESERVED = 2'h3;

   // outcome of the last transmission as reported by the mac
   typedef struct packed {
      logic late_collision_flag;
      logic collision_limit_flag;
      logic excessive_defer_flag;
      logic defer_flag;
      logic transmit_checksum_mismatch;
      logic [3:0] collision_count;
   } ecsr_tx_outcome_t;

   // engine start handshake carrier: start pulse out, done pulse in
   typedef struct packed {
      logic exp_go;
      logic cipher_go;
      logic copy_go;
      logic tx_go;
   } ecsr_starts_t;

   typedef struct packed {
      logic exp_done;
      logic cipher_done;
      logic copy_done;
      logic tx_done;
   } ecsr_dones_t;
endpackage

// ==== hdl/ecsr_regs.sv ====
/*
 control and status register group of a 10/100 ethernet controller, apb slave.
 assumes engines, mac, receive filters and interrupt flag logic sit outside and hand
 back done pulses and status levels synchronous to ref_clk_in.
*/
`timescale 1ns/1ps
module ecsr_regs
   import ecsr_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // engine handshakes
   output ecsr_starts_t starts_out,
   input wire ecsr_dones_t dones_in,
   // engine and mac configuration levels
   output logic digest_engine_enable_out,
   output logic digest_load_initial_value_out,
   output logic digest_last_block_out,
   output logic [1:0] cipher_operation_select_out,
   output logic copy_engine_copy_enable_out,
   output logic checksum_seed_select_out,
   output logic checksum_disable_out,
   output logic receive_enable_out,
   // flow control
   input wire logic full_duplex_select_in,
   input wire logic flow_done_in,
   input wire logic flow_engine_idle_in,
   output logic [1:0] flow_request_out,
   output logic backpressure_out,
   output logic [15:0] pause_timer_select_out,
   input wire logic [15:0] pause_timer_value_in,
   // mac and receive status
   input wire logic tx_outcome_valid_in,
   input wire ecsr_tx_outcome_t tx_outcome_in,
   input wire logic packet_stored_in,
   input wire logic receive_active_in,
   input wire logic clock_ready_in,
   input wire logic phy_full_duplex_in,
   input wire logic phy_link_up_in,
   input wire logic interrupt_pending_in,
   input wire logic global_interrupt_enable_in,
   // status to the pins
   output logic int_n_out,
   output logic [7:0] received_packet_count_out
);

   logic [15:0] ctrl_reg;
   logic [15:0] scratch_reg;
   ecsr_tx_outcome_t txstat_reg;
   logic [7:0] received_packet_count_reg;
   logic flow_idle_reg;
   logic [31:0] rdata_next;
   logic wr_access;
   logic rd_access;
   logic decrement;
   logic mapped;

   // every check below lives in the one clock domain and is quiet during reset
   default clocking cb_main @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   assign wr_access = psel_in & penable_in & pwrite_in;
   assign rd_access = psel_in & ~penable_in & ~pwrite_in;
   assign mapped = (paddr_in == ECSR_OFF_CONTROL) | (paddr_in == ECSR_OFF_TXSTAT) |
                   (paddr_in == ECSR_OFF_STATUS) | (paddr_in == ECSR_OFF_SCRATCH);

   logic [15:0] ctrl_wr;
   assign ctrl_wr = lane_merge(ctrl_reg, pwdata_in, pstrb_in);
   assign decrement = wr_access & (paddr_in == ECSR_OFF_CONTROL) & pstrb_in[1] & ctrl_wr[ECSR_BIT_PACKET_COUNT_DECREMENT];

   // control register: start bits are set by software and cleared only by their done pulse
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         ctrl_reg <= ECSR_CONTROL_RESET;
      end else begin
         if (wr_access && paddr_in == ECSR_OFF_CONTROL) begin
            ctrl_reg <= ctrl_wr;
            // busy starts cannot be dropped by a write of zero
            ctrl_reg[ECSR_BIT_EXP] <= ctrl_reg[ECSR_BIT_EXP] | ctrl_wr[ECSR_BIT_EXP];
            ctrl_reg[ECSR_BIT_CIPHER] <= ctrl_reg[ECSR_BIT_CIPHER] | ctrl_wr[ECSR_BIT_CIPHER];
            ctrl_reg[ECSR_BIT_COPY] <= ctrl_reg[ECSR_BIT_COPY] | ctrl_wr[ECSR_BIT_COPY];
            ctrl_reg[ECSR_BIT_TXREQ] <= ctrl_reg[ECSR_BIT_TXREQ] | ctrl_wr[ECSR_BIT_TXREQ];
            ctrl_reg[ECSR_BIT_PACKET_COUNT_DECREMENT] <= 1'b0;
         end else begin
            if (dones_in.exp_done) begin
               ctrl_reg[ECSR_BIT_EXP] <= 1'b0;
            end
            if (dones_in.cipher_done) begin
               ctrl_reg[ECSR_BIT_CIPHER] <= 1'b0;
            end
            if (dones_in.copy_done) begin
               ctrl_reg[ECSR_BIT_COPY] <= 1'b0;
            end
            if (dones_in.tx_done) begin
               ctrl_reg[ECSR_BIT_TXREQ] <= 1'b0;
            end
            // one-shot flow codes return to idle once their pause frame is out
            if (flow_done_in && full_duplex_select_in &&
                (ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO] == ECSR_FLOW_END ||
                 ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO] == ECSR_FLOW_SINGLE)) begin
               ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO] <= ECSR_FLOW_IDLE;
            end
         end
      end
   end

   // start pulses: one cycle when a start bit rises from a write; cipher pulses only with a non-reserved code
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         starts_out <= '0;
      end else begin
         starts_out.exp_go <= wr_access && paddr_in == ECSR_OFF_CONTROL && !ctrl_reg[ECSR_BIT_EXP] &&
                              ctrl_wr[ECSR_BIT_EXP];
         starts_out.cipher_go <= wr_access && paddr_in == ECSR_OFF_CONTROL && !ctrl_reg[ECSR_BIT_CIPHER] &&
                                 ctrl_wr[ECSR_BIT_CIPHER] &&
                                 ctrl_wr[ECSR_CIPH_HI:ECSR_CIPH_LO] != ECSR_CIPH_RESERVED;
         starts_out.copy_go <= wr_access && paddr_in == ECSR_OFF_CONTROL && !ctrl_reg[ECSR_BIT_COPY] &&
                               ctrl_wr[ECSR_BIT_COPY];
         starts_out.tx_go <= wr_access && paddr_in == ECSR_OFF_CONTROL && !ctrl_reg[ECSR_BIT_TXREQ] &&
                             ctrl_wr[ECSR_BIT_TXREQ];
      end
   end

   // configuration levels to the engines and receive path
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         digest_engine_enable_out <= 1'b0;
         digest_load_initial_value_out <= 1'b0;
         digest_last_block_out <= 1'b0;
         cipher_operation_select_out <= 2'h0;
         copy_engine_copy_enable_out <= 1'b0;
         checksum_seed_select_out <= 1'b0;
         checksum_disable_out <= 1'b0;
         receive_enable_out <= 1'b0;
      end else begin
         digest_engine_enable_out <= ctrl_reg[ECSR_BIT_DIG_EN];
         digest_load_initial_value_out <= ctrl_reg[ECSR_BIT_DIG_IV];
         digest_last_block_out <= ctrl_reg[ECSR_BIT_DIG_LAST];
         cipher_operation_select_out <= ctrl_reg[ECSR_CIPH_HI:ECSR_CIPH_LO];
         copy_engine_copy_enable_out <= ctrl_reg[ECSR_BIT_COPY_EN];
         checksum_seed_select_out <= ctrl_reg[ECSR_BIT_SEED];
         checksum_disable_out <= ctrl_reg[ECSR_BIT_NOCS];
         receive_enable_out <= ctrl_reg[ECSR_BIT_RECEIVE_ENABLE];
      end
   end

   // flow control steering by duplex; host keeps code stable while busy
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         flow_request_out <= ECSR_FLOW_IDLE;
         backpressure_out <= 1'b0;
         pause_timer_select_out <= ECSR_PAUSE_ZERO;
         flow_idle_reg <= 1'b1;
      end else begin
         flow_request_out <= full_duplex_select_in ? ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO] : ECSR_FLOW_IDLE;
         backpressure_out <= !full_duplex_select_in &&
                             ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO] != ECSR_FLOW_IDLE;
         pause_timer_select_out <= (ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO] == ECSR_FLOW_END) ?
                                   ECSR_PAUSE_ZERO : pause_timer_value_in;
         flow_idle_reg <= flow_engine_idle_in && ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO] == ECSR_FLOW_IDLE;
      end
   end

   // transmit outcome captured whole at the end of each transmission
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         txstat_reg <= '0;
      end else if (tx_outcome_valid_in) begin
         txstat_reg <= tx_outcome_in;
      end
   end

   // packet count: a new packet and a decrement in one cycle cancel out
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         received_packet_count_reg <= 8'h00;
      end else if (packet_stored_in && !decrement) begin
         received_packet_count_reg <= received_packet_count_reg + 8'h01;
      end else if (decrement && !packet_stored_in && received_packet_count_reg != 8'h00) begin
         received_packet_count_reg <= received_packet_count_reg - 8'h01;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         scratch_reg <= ECSR_SCRATCH_RESET;
      end else if (wr_access && paddr_in == ECSR_OFF_SCRATCH) begin
         scratch_reg <= lane_merge(scratch_reg, pwdata_in, pstrb_in);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         int_n_out <= 1'b1;
         received_packet_count_out <= 8'h00;
      end else begin
         int_n_out <= !(interrupt_pending_in && global_interrupt_enable_in);
         received_packet_count_out <= received_packet_count_reg;
      end
   end

   // read mux; all status bits unused by the layout read zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (paddr_in)
         ECSR_OFF_CONTROL: rdata_next[15:0] = ctrl_reg;
         ECSR_OFF_TXSTAT: rdata_next[15:0] = {5'h00, txstat_reg.late_collision_flag,
                                             txstat_reg.collision_limit_flag, txstat_reg.excessive_defer_flag,
                                             txstat_reg.defer_flag, 2'h0, txstat_reg.transmit_checksum_mismatch,
                                             txstat_reg.collision_count};
         ECSR_OFF_STATUS: rdata_next[15:0] = {interrupt_pending_in, flow_idle_reg, receive_active_in,
                                             clock_ready_in, 1'b0, phy_full_duplex_in, 1'b0, phy_link_up_in,
                                             received_packet_count_reg};
         ECSR_OFF_SCRATCH: rdata_next[15:0] = scratch_reg;
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // no wait state: data captured at setup, ready in the access phase
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !mapped;
         if (rd_access) begin
            prdata_out <= rdata_next;
         end
      end
   end

   chk_decrement_count: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      decrement && !packet_stored_in && received_packet_count_reg != 8'h00 |=> received_packet_count_reg == $past(received_packet_count_reg) - 8'h01)
      else $error("packet count did not decrement");
   chk_packet_count_decrement_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !ctrl_reg[ECSR_BIT_PACKET_COUNT_DECREMENT]) else $error("decrement bit stuck");
   chk_tx_done_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      dones_in.tx_done && !wr_access |=> !ctrl_reg[ECSR_BIT_TXREQ]) else $error("transmit request not cleared");
   chk_exp_pulse: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      starts_out.exp_go |-> ctrl_reg[ECSR_BIT_EXP]) else $error("exp start without busy");
   chk_backpressure: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      backpressure_out |-> !$past(full_duplex_select_in)) else $error("backpressure in full duplex");
   chk_int_pin: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      interrupt_pending_in && global_interrupt_enable_in |=> !int_n_out) else $error("interrupt pin not low");
   chk_rx_enable: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      receive_enable_out == $past(ctrl_reg[ECSR_BIT_RECEIVE_ENABLE])) else $error("receive enable mismatch");
   chk_flow_end: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      ##1 flow_request_out == ECSR_FLOW_END |-> pause_timer_select_out == ECSR_PAUSE_ZERO)
      else $error("end pause timer not zero");

   // a write to the control word, and a start request on an idle engine
   sequence seq_ctrl_write;
      wr_access && paddr_in == ECSR_OFF_CONTROL;
   endsequence
   sequence seq_exp_request;
      seq_ctrl_write ##0 !ctrl_reg[ECSR_BIT_EXP] && ctrl_wr[ECSR_BIT_EXP];
   endsequence

   chk_exp_request: assert property (
      seq_exp_request |=> starts_out.exp_go && ctrl_reg[ECSR_BIT_EXP])
      else $error("exp request not started");
   chk_exp_done: assert property (
      dones_in.exp_done && !wr_access |=> !ctrl_reg[ECSR_BIT_EXP])
      else $error("exp busy not cleared");
   chk_cipher_pulse: assert property (
      starts_out.cipher_go |-> ctrl_reg[ECSR_BIT_CIPHER])
      else $error("cipher start without busy");
   chk_cipher_done: assert property (
      dones_in.cipher_done && !wr_access |=> !ctrl_reg[ECSR_BIT_CIPHER])
      else $error("cipher busy not cleared");
   // a reserved code must never reach the engine as a start
   chk_reserved_code: assert property (
      seq_ctrl_write ##0 ctrl_wr[ECSR_CIPH_HI:ECSR_CIPH_LO] == ECSR_CIPH_RESERVED |=> !starts_out.cipher_go)
      else $error("reserved cipher code started");
   chk_cipher_select: assert property (
      cipher_operation_select_out == $past(ctrl_reg[ECSR_CIPH_HI:ECSR_CIPH_LO]))
      else $error("cipher select mismatch");
   chk_copy_pulse: assert property (
      starts_out.copy_go |-> ctrl_reg[ECSR_BIT_COPY])
      else $error("copy start without busy");
   chk_copy_done: assert property (
      dones_in.copy_done && !wr_access |=> !ctrl_reg[ECSR_BIT_COPY])
      else $error("copy busy not cleared");
   chk_tx_pulse: assert property (
      starts_out.tx_go |-> ctrl_reg[ECSR_BIT_TXREQ])
      else $error("transmit start without request");
   chk_digest_levels: assert property (
      digest_engine_enable_out == $past(ctrl_reg[ECSR_BIT_DIG_EN]) &&
      digest_load_initial_value_out == $past(ctrl_reg[ECSR_BIT_DIG_IV]))
      else $error("digest levels mismatch");
   chk_last_block: assert property (
      digest_last_block_out == $past(ctrl_reg[ECSR_BIT_DIG_LAST]))
      else $error("last block level mismatch");
   chk_copy_enable: assert property (
      copy_engine_copy_enable_out == $past(ctrl_reg[ECSR_BIT_COPY_EN]))
      else $error("copy enable mismatch");
   chk_checksum_ctrl: assert property (
      checksum_seed_select_out == $past(ctrl_reg[ECSR_BIT_SEED]) &&
      checksum_disable_out == $past(ctrl_reg[ECSR_BIT_NOCS]))
      else $error("checksum controls mismatch");
   chk_flow_full: assert property (
      flow_request_out == ($past(full_duplex_select_in) ? $past(ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO]) :
                           ECSR_FLOW_IDLE))
      else $error("flow request mismatch");
   chk_one_shot: assert property (
      flow_done_in && full_duplex_select_in && !wr_access &&
      ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO] == ECSR_FLOW_SINGLE |=> ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO] == ECSR_FLOW_IDLE)
      else $error("single pause code not cleared");
   // half duplex with any code set must hold the line busy
   chk_flow_half: assert property (
      !$past(full_duplex_select_in) && $past(ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO]) != ECSR_FLOW_IDLE |->
      backpressure_out)
      else $error("backpressure missing");
   chk_flow_idle: assert property (
      flow_idle_reg == $past(flow_engine_idle_in && ctrl_reg[ECSR_FLOW_HI:ECSR_FLOW_LO] == ECSR_FLOW_IDLE))
      else $error("flow idle mismatch");
   chk_txstat_load: assert property (
      tx_outcome_valid_in |=> txstat_reg == $past(tx_outcome_in))
      else $error("transmit outcome not captured");
   chk_count_up: assert property (
      packet_stored_in && !decrement && received_packet_count_reg != 8'hff |=> received_packet_count_reg == $past(received_packet_count_reg) + 8'h01)
      else $error("packet count did not increment");
   chk_count_hold: assert property (
      !packet_stored_in && !decrement |=> received_packet_count_reg == $past(received_packet_count_reg))
      else $error("packet count moved without cause");
   chk_count_pin: assert property (
      received_packet_count_out == $past(received_packet_count_reg))
      else $error("packet count pin mismatch");
   chk_int_high: assert property (
      !(interrupt_pending_in && global_interrupt_enable_in) |=> int_n_out)
      else $error("interrupt pin not high");
   // ready answers only the setup cycle, so every transfer completes with no wait state
   chk_ready_pulse: assert property (
      pready_out |-> $past(psel_in) && !$past(penable_in))
      else $error("ready outside access phase");
   chk_slverr_ready: assert property (
      pslverr_out |-> pready_out)
      else $error("error without ready");
endmodule

// ==== tb/ecsr_engine_model.sv ====
/*
 behavioural model of the engines and mac that answer the start pulses of the
 register group. assumes one clock and the same synchronous reset as the registers.
*/
`timescale 1ns/1ps
module ecsr_engine_model
   import ecsr_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // handshake with the register group
   input wire ecsr_starts_t starts_in,
   input wire logic [7:0] delay_in,
   output ecsr_dones_t dones_out
);
   logic [7:0] busy_reg [4];
   // done pulse a programmable number of cycles after each start
   always_ff @(posedge ref_clk_in) begin
      for (int k = 0; k < 4; k++) begin
         dones_out[k] <= 1'b0;
         if (sys_rst_in) begin
            busy_reg[k] <= 8'h00;
         end else if (starts_in[k]) begin
            busy_reg[k] <= delay_in;
         end else if (busy_reg[k] == 8'h01) begin
            busy_reg[k] <= 8'h00;
            dones_out[k] <= 1'b1;
         end else if (busy_reg[k] != 8'h00) begin
            busy_reg[k] <= busy_reg[k] - 8'h01;
         end
      end
   end
endmodule

// ==== tb/ethernet_control_status_regs_tb_top.sv ====
/*
 self-checking bench for the control and status register group over apb.
 assumes the engine model answers start pulses; mac status is driven here.
*/
`timescale 1ns/1ps
module ethernet_control_status_regs_tb_top;
   import ecsr_pkg::*;
   logic clk, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, prdy, perr, err, int_n, bp;
   logic fdx = 1'b1, fdone = 1'b0, txv = 1'b0, pstore = 1'b0, ckrdy = 1'b0;
   logic rxact = 1'b0, pdx = 1'b0, plnk = 1'b0, ipend = 1'b0, gie = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0, prd, rd;
   logic [3:0] pstrb = 4'hf, strb = 4'hf;
   logic [7:0] dly = 8'h14, cnt;
   logic [8:0] cfg;
   logic [1:0] fl_req;
   logic [15:0] ptim;
   ecsr_starts_t st;
   ecsr_dones_t dn;
   ecsr_tx_outcome_t txo = '0;
   ecsr_tx_outcome_t tp[2] = '{9'h155, 9'h0aa};
   logic [31:0] te[2] = '{32'h515, 32'h28a};
   int sb[4] = '{1, 5, 11, 15};
   int fc[3] = '{3, 1, 2};
   int go_cnt[4] = '{0, 0, 0, 0};
   int n_mismatch = 0, n_tests = 0, cyc = 0;

   ecsr_regs dut (.ref_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(pstrb), .prdata_out(prd), .pready_out(prdy),
      .pslverr_out(perr), .starts_out(st), .dones_in(dn), .digest_engine_enable_out(cfg[8]),
      .digest_load_initial_value_out(cfg[7]), .digest_last_block_out(cfg[6]),
      .cipher_operation_select_out(cfg[5:4]), .copy_engine_copy_enable_out(cfg[3]),
      .checksum_seed_select_out(cfg[2]), .checksum_disable_out(cfg[1]), .receive_enable_out(cfg[0]),
      .full_duplex_select_in(fdx), .flow_done_in(fdone), .flow_engine_idle_in(1'b1),
      .flow_request_out(fl_req), .backpressure_out(bp), .pause_timer_select_out(ptim),
      .pause_timer_value_in(16'h1234), .tx_outcome_valid_in(txv), .tx_outcome_in(txo),
      .packet_stored_in(pstore), .receive_active_in(rxact), .clock_ready_in(ckrdy),
      .phy_full_duplex_in(pdx), .phy_link_up_in(plnk), .interrupt_pending_in(ipend),
      .global_interrupt_enable_in(gie), .int_n_out(int_n), .received_packet_count_out(cnt));
   ecsr_engine_model eng (.ref_clk_in(clk), .sys_rst_in(rst), .starts_in(st), .delay_in(dly), .dones_out(dn));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // hang guard: the whole run needs a few hundred cycles
   always @(posedge clk) begin
      cyc++;
      for (int k = 0; k < 4; k++) begin
         if (st[k] === 1'b1) go_cnt[k]++;
      end
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      pstrb <= strb;
      @(posedge clk);
      pen <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (prdy !== 1'b1 && i < 50);
      if (i == 50) n_mismatch++;
      rd = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("int_n", 32'h1, 32'(int_n));
      rchk(ECSR_OFF_STATUS, 32'h4000, "status");
      apb(1'b1, ECSR_OFF_SCRATCH, 32'h1234beef);
      strb = 4'h2;
      apb(1'b1, ECSR_OFF_SCRATCH, 32'h0000a5c3);
      strb = 4'hf;
      rchk(ECSR_OFF_SCRATCH, 32'ha5ef, "scratch");
      ckrdy <= 1'b1;
      rchk(ECSR_OFF_CONTROL, 32'h0, "control");
      apb(1'b1, ECSR_OFF_CONTROL, 32'h741d);
      repeat (2) @(negedge clk);
      chk("config", 32'h1ef, 32'(cfg));
      rchk(ECSR_OFF_CONTROL, 32'h741d, "control");
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, ECSR_OFF_CONTROL, 32'(c) << 9);
         repeat (2) @(negedge clk);
         chk("cipher_op", 32'(c) << 4, 32'(cfg));
      end
      // slow engines: busy must survive a zero write
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, ECSR_OFF_CONTROL, 32'h1 << sb[k]);
         apb(1'b1, ECSR_OFF_CONTROL, 32'h0);
         rchk(ECSR_OFF_CONTROL, 32'h1 << sb[k], "busy");
         repeat (25) @(posedge clk);
         rchk(ECSR_OFF_CONTROL, 32'h0, "idle");
         chk("start_pulse", 32'h1, 32'(go_cnt[k]));
      end
      dly = 8'h01;
      apb(1'b1, ECSR_OFF_CONTROL, 32'h2);
      repeat (4) @(posedge clk);
      rchk(ECSR_OFF_CONTROL, 32'h0, "prompt_tx");
      pstore <= 1'b1;
      repeat (3) @(posedge clk);
      pstore <= 1'b0;
      repeat (2) @(negedge clk);
      chk("count_pin", 32'h3, 32'(cnt));
      // second pass decrements past zero, which must stay at zero
      for (int j = 0; j < 2; j++) begin
         apb(1'b1, ECSR_OFF_CONTROL, 32'h100);
         apb(1'b1, ECSR_OFF_CONTROL, 32'h100);
         rchk(ECSR_OFF_STATUS, (j == 0) ? 32'h5001 : 32'h5000, "count");
      end
      chk("count_pin", 32'h0, 32'(cnt));
      rchk(ECSR_OFF_CONTROL, 32'h0, "decrement_clear");
      for (int j = 0; j < 3; j++) begin
         apb(1'b1, ECSR_OFF_CONTROL, 32'(fc[j]) << 6);
         repeat (2) @(negedge clk);
         chk("flow_req", 32'(fc[j]), 32'(fl_req));
         chk("pause_sel", (fc[j] == 3) ? 32'h0 : 32'h1234, 32'(ptim));
         @(posedge clk);
         fdone <= 1'b1;
         @(posedge clk);
         fdone <= 1'b0;
         rchk(ECSR_OFF_CONTROL, (fc[j] == 2) ? 32'h80 : 32'h0, "flow_clear");
      end
      apb(1'b1, ECSR_OFF_CONTROL, 32'h0);
      repeat (3) @(posedge clk);
      fdx <= 1'b0;
      for (int j = 1; j < 4; j++) begin
         apb(1'b1, ECSR_OFF_CONTROL, 32'(j) << 6);
         repeat (2) @(negedge clk);
         chk("backpressure", 32'h1, {fl_req, 29'h0, bp});
         rchk(ECSR_OFF_STATUS, 32'h1000, "flow_busy");
         apb(1'b1, ECSR_OFF_CONTROL, 32'h0);
      end
      apb(1'b1, ECSR_OFF_CONTROL, 32'h0);
      repeat (2) @(negedge clk);
      chk("backpressure", 32'h0, 32'(bp));
      fdx <= 1'b1;
      for (int j = 0; j < 2; j++) begin
         @(posedge clk);
         txo <= tp[j];
         txv <= 1'b1;
         @(posedge clk);
         txv <= 1'b0;
         txo <= '0;
         rchk(ECSR_OFF_TXSTAT, te[j], "tx_status");
      end
      apb(1'b1, ECSR_OFF_TXSTAT, 32'hffff);
      rchk(ECSR_OFF_TXSTAT, 32'h28a, "tx_status_ro");
      {rxact, pdx, plnk, ipend, gie} <= 5'h1f;
      rchk(ECSR_OFF_STATUS, 32'hf500, "status");
      chk("int_n", 32'h0, 32'(int_n));
      gie <= 1'b0;
      rchk(ECSR_OFF_STATUS, 32'hf500, "status");
      chk("int_n", 32'h1, 32'(int_n));
      {rxact, ipend} <= 2'h0;
      rchk(ECSR_OFF_STATUS, 32'h5500, "status");
      apb(1'b1, 12'h010, 32'h5555);
      chk("slverr", 32'h1, 32'(err));
      apb(1'b0, 12'h010, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      chk("unmapped", 32'h0, rd);
      rchk(ECSR_OFF_SCRATCH, 32'ha5ef, "scratch");
      stop_test();
   end
endmodule
